/* verilog/qprs_cfg.svh */
// Constants of the quadrature pulse rate scaler: offsets, reset values and timing.
`ifndef QPRS_CFG_SVH
`define QPRS_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define QPRS_OFS_CTRL 5'h00
`define QPRS_OFS_FACTOR1 5'h04
`define QPRS_OFS_FACTOR2 5'h08
`define QPRS_OFS_MARKER_PPR 5'h0c
`define QPRS_OFS_CTLIN_CFG 5'h10
`define QPRS_OFS_STATUS 5'h14
`define QPRS_OFS_POSITION 5'h18

// ------------------------------------------------------------
// Field positions, reset values and factor limits
// ------------------------------------------------------------
`define QPRS_CTRL_DUAL 0
`define QPRS_CTRL_ZSYNC 1
`define QPRS_CTRL_INVERT 2
`define QPRS_CTRL_RST 3'h1
`define QPRS_FACTOR_RST 17'h02710
`define QPRS_FACTOR_MIN 17'h00005
`define QPRS_FACTOR_MAX 17'h1869f
`define QPRS_PPR_RST 16'h0400
`define QPRS_CTLIN_RST 16'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define QPRS_CLK_PERIOD_NS 40
`define QPRS_OUT_PERIOD_NS 1000
`define QPRS_EDGE_GAP_CYC ((`QPRS_OUT_PERIOD_NS / 4 + `QPRS_CLK_PERIOD_NS - 1) / `QPRS_CLK_PERIOD_NS)

`endif

/* verilog/qprs_pkg.sv */
// Types shared by the quadrature pulse rate scaler.
package qprs_pkg;

    typedef logic [31:0] qprs_word_t;

    typedef enum logic [1:0] {
        QPRS_PH0 = 2'b00,
        QPRS_PH1 = 2'b01,
        QPRS_PH2 = 2'b10,
        QPRS_PH3 = 2'b11
    } qprs_phase_e;

    typedef enum logic [1:0] {
        QPRS_FN_NONE = 2'b00,
        QPRS_FN_LOCK = 2'b01,
        QPRS_FN_REVERSE = 2'b10,
        QPRS_FN_FREEZE = 2'b11
    } qprs_func_e;

endpackage

/* verilog/qprs_top.sv */
// Quadrature pulse rate scaler with an AHB-Lite register slave.
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`include "qprs_cfg.svh"

module qprs_top #(
    parameter int CTL_INPUTS = 4,
    parameter int GAP_WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire qprs_pkg::qprs_word_t hwdata,
    input wire logic hready,
    output qprs_pkg::qprs_word_t hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    input wire logic [CTL_INPUTS-1:0] ctl_in,
    output logic out_a,
    output logic out_a_n,
    output logic out_b,
    output logic out_b_n,
    output logic out_z,
    output logic out_z_n,
    output logic key_lock
);
    import qprs_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    initial begin
        if (CTL_INPUTS != 4) begin
            $error("qprs_top: the control configuration register serves exactly four inputs");
        end
        if (GAP_WIDTH < 8 || GAP_WIDTH > 24) begin
            $error("qprs_top: GAP_WIDTH must lie between 8 and 24");
        end
    end

    localparam logic [GAP_WIDTH-1:0] EDGE_GAP = GAP_WIDTH'(`QPRS_EDGE_GAP_CYC - 1);
    localparam logic [GAP_WIDTH-1:0] GAP_MAX = '1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic dph_wr;
        logic [4:0] dph_ofs;
        qprs_word_t rdata;
        logic [2:0] ctrl;
        logic [16:0] factor1;
        logic [16:0] factor2;
        logic [15:0] ppr;
        logic [15:0] ctlin_cfg;
        logic [1:0] in_ab;
        logic in_z;
        logic signed [31:0] acc;
        qprs_phase_e phase;
        logic [GAP_WIDTH-1:0] gap;
        logic [GAP_WIDTH-1:0] last_gap;
        logic last_up;
        logic [17:0] mpos;
        logic [31:0] pos;
        logic oa;
        logic ob;
        logic oz;
        logic lock;
        logic reverse;
        logic freeze;
    } qprs_state_s;

    qprs_state_s s_q;
    qprs_state_s s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Quadrature step between two A/B samples: +1, -1 or 0.
    function automatic logic signed [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
        logic signed [1:0] r;
        r = 2'sb00;
        unique case ({prev, cur})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'sb01;
            4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'sb11;
            default: r = 2'sb00;
        endcase
        return r;
    endfunction

    function automatic logic signed [31:0] widen(input logic [16:0] v);
        return signed'({15'h0000, v});
    endfunction

    function automatic logic factor_ok(input logic [31:0] v);
        return v[31:17] == 15'h0000 && v[16:0] >= `QPRS_FACTOR_MIN && v[16:0] <= `QPRS_FACTOR_MAX;
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic act;
    logic [3:0] fn_cfg;
    logic signed [1:0] in_step;
    logic signed [31:0] acc_in;
    logic step_up;
    logic step_dn;
    logic [17:0] mtop;
    logic [4:0] ofs;

    always_comb begin
        s_d = s_q;
        act = 1'b0;
        fn_cfg = 4'h0;
        in_step = 2'sb00;
        acc_in = 32'sh0;
        step_up = 1'b0;
        step_dn = 1'b0;
        mtop = 18'h00000;
        ofs = haddr[4:0];

        // Control inputs: each nibble holds polarity in bit 0 and function above it.
        s_d.lock = 1'b0;
        s_d.reverse = 1'b0;
        s_d.freeze = 1'b0;
        for (int i = 0; i < 4; i++) begin
            fn_cfg = s_q.ctlin_cfg[4*i +: 4];
            act = ctl_in[i] == fn_cfg[0];
            if (act) begin
                unique case (qprs_func_e'(fn_cfg[2:1]))
                    QPRS_FN_NONE: ;
                    QPRS_FN_LOCK: s_d.lock = 1'b1;
                    QPRS_FN_REVERSE: s_d.reverse = 1'b1;
                    QPRS_FN_FREEZE: s_d.freeze = 1'b1;
                endcase
            end
        end

        // Input decoding; a sampled level is trusted as the partner stays within its frequency limit.
        s_d.in_ab = {enc_a, enc_b};
        s_d.in_z = enc_z;
        if (s_q.ctrl[`QPRS_CTRL_DUAL]) begin
            in_step = quad_step(s_q.in_ab, {enc_a, enc_b});
        end else if (enc_a && !s_q.in_ab[1]) begin
            in_step = 2'sb01;
        end
        if (s_q.ctrl[`QPRS_CTRL_INVERT] ^ s_q.reverse) begin
            in_step = -in_step;
        end

        // Every input step moves the accumulator by factor 1; output steps outside freeze remove factor 2.
        if (in_step == 2'sb01) begin
            acc_in = widen(s_q.factor1);
        end else if (in_step == 2'sb11) begin
            acc_in = -widen(s_q.factor1);
        end

        // The edge gap keeps each output quarter period long enough for 1 MHz and for 90 degrees.
        s_d.gap = (s_q.gap == GAP_MAX) ? s_q.gap : s_q.gap + 1'b1;
        if (s_q.freeze) begin
            if (s_q.gap >= EDGE_GAP && s_q.gap >= s_q.last_gap) begin
                step_up = s_q.last_up;
                step_dn = !s_q.last_up;
            end
        end else if (s_q.gap >= EDGE_GAP) begin
            step_up = s_q.acc >= widen(s_q.factor2);
            step_dn = s_q.acc <= -widen(s_q.factor2);
        end

        // The remainder stays signed across input pulses, so direction changes cancel exactly.
        s_d.acc = s_q.acc + acc_in;
        if (!s_q.freeze && step_up) begin
            s_d.acc = s_d.acc - widen(s_q.factor2);
        end else if (!s_q.freeze && step_dn) begin
            s_d.acc = s_d.acc + widen(s_q.factor2);
        end

        // Output quadrature generator and marker position.
        mtop = {s_q.ppr, 2'b00} - 18'h00001;
        if (step_up || step_dn) begin
            s_d.last_gap = s_q.gap;
            s_d.gap = '0;
            s_d.last_up = step_up;
            s_d.pos = step_up ? s_q.pos + 32'h1 : s_q.pos - 32'h1;
            s_d.phase = qprs_phase_e'(step_up ? s_q.phase + 2'b01 : s_q.phase - 2'b01);
            if (step_up) begin
                s_d.mpos = (s_q.mpos >= mtop) ? 18'h00000 : s_q.mpos + 18'h00001;
            end else begin
                s_d.mpos = (s_q.mpos == 18'h00000 || s_q.mpos > mtop) ? mtop : s_q.mpos - 18'h00001;
            end
        end
        // A missing marker input simply never produces a rising edge here.
        if (s_q.ctrl[`QPRS_CTRL_ZSYNC] && enc_z && !s_q.in_z) begin
            s_d.mpos = 18'h00000;
        end

        unique case (s_d.phase)
            QPRS_PH0: {s_d.oa, s_d.ob} = 2'b00;
            QPRS_PH1: {s_d.oa, s_d.ob} = 2'b10;
            QPRS_PH2: {s_d.oa, s_d.ob} = 2'b11;
            QPRS_PH3: {s_d.oa, s_d.ob} = 2'b01;
        endcase
        s_d.oz = s_q.ppr != 16'h0000 && s_d.mpos == 18'h00000;

        // Bus data phase: writes take effect at the edge that ends it.
        s_d.dph_wr = 1'b0;
        if (s_q.dph_wr) begin
            unique case (s_q.dph_ofs)
                `QPRS_OFS_CTRL: s_d.ctrl = hwdata[2:0];
                `QPRS_OFS_FACTOR1: s_d.factor1 = factor_ok(hwdata) ? hwdata[16:0] : s_q.factor1;
                `QPRS_OFS_FACTOR2: s_d.factor2 = factor_ok(hwdata) ? hwdata[16:0] : s_q.factor2;
                `QPRS_OFS_MARKER_PPR: s_d.ppr = hwdata[15:0];
                `QPRS_OFS_CTLIN_CFG: s_d.ctlin_cfg = hwdata[15:0];
                default: ;
            endcase
        end

        // Bus address phase: read data is captured now so it stands during the data phase.
        if (hsel && htrans[1] && hready) begin
            s_d.dph_wr = hwrite && hsize == 3'b010 && haddr[31:5] == 27'h0;
            s_d.dph_ofs = ofs;
            s_d.rdata = 32'h0;
            if (!hwrite && haddr[31:5] == 27'h0) begin
                unique case (ofs)
                    `QPRS_OFS_CTRL: s_d.rdata = {29'h0, s_q.ctrl};
                    `QPRS_OFS_FACTOR1: s_d.rdata = {15'h0, s_q.factor1};
                    `QPRS_OFS_FACTOR2: s_d.rdata = {15'h0, s_q.factor2};
                    `QPRS_OFS_MARKER_PPR: s_d.rdata = {16'h0, s_q.ppr};
                    `QPRS_OFS_CTLIN_CFG: s_d.rdata = {16'h0, s_q.ctlin_cfg};
                    `QPRS_OFS_STATUS: s_d.rdata = {27'h0, s_q.oz, s_q.last_up, s_q.freeze, s_q.reverse, s_q.lock};
                    `QPRS_OFS_POSITION: s_d.rdata = s_q.pos;
                    default: s_d.rdata = 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{
                dph_wr: 1'b0,
                dph_ofs: 5'h00,
                rdata: 32'h0,
                ctrl: `QPRS_CTRL_RST,
                factor1: `QPRS_FACTOR_RST,
                factor2: `QPRS_FACTOR_RST,
                ppr: `QPRS_PPR_RST,
                ctlin_cfg: `QPRS_CTLIN_RST,
                in_ab: 2'b00,
                in_z: 1'b0,
                acc: 32'sh0,
                phase: QPRS_PH0,
                gap: '0,
                last_gap: '0,
                last_up: 1'b1,
                mpos: 18'h00000,
                pos: 32'h0,
                oa: 1'b0,
                ob: 1'b0,
                oz: 1'b1,
                lock: 1'b0,
                reverse: 1'b0,
                freeze: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign out_a = s_q.oa;
    assign out_a_n = !s_q.oa;
    assign out_b = s_q.ob;
    assign out_b_n = !s_q.ob;
    assign out_z = s_q.oz;
    assign out_z_n = !s_q.oz;
    assign key_lock = s_q.lock;

endmodule

/* tb/qprs_properties.sv */
// Port checker for the quadrature pulse rate scaler.
module qprs_checker #(
    parameter int CTL_INPUTS = 4,
    parameter int GAP_WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire qprs_pkg::qprs_word_t hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [CTL_INPUTS-1:0] ctl_in,
    input wire logic out_a,
    input wire logic out_a_n,
    input wire logic out_b,
    input wire logic out_b_n,
    input wire logic out_z,
    input wire logic out_z_n,
    input wire logic key_lock
);
    import qprs_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Helper: cycles since a control input moved or a write went by
    // ------------------------------------------------------------
    logic [CTL_INPUTS-1:0] ctl_q;
    logic wr_q;
    logic [2:0] age_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_q <= '0;
            wr_q <= 1'b0;
            age_q <= 3'h7;
        end else begin
            ctl_q <= ctl_in;
            wr_q <= hsel && htrans[1] && hready && hwrite;
            age_q <= (ctl_in != ctl_q || wr_q) ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
        end
    end
    a_comp_a: assert property (out_a_n == !out_a) else $error("out_a_n not inverse");
    a_comp_b: assert property (out_b_n == !out_b) else $error("out_b_n not inverse");
    a_comp_z: assert property (out_z_n == !out_z) else $error("out_z_n not inverse");
    a_edge_gap: assert property (($changed(out_a) || $changed(out_b)) |=>
        !($changed(out_a) || $changed(out_b)) [*6]) else $error("output edges too close");
    a_single_edge: assert property (!($changed(out_a) && $changed(out_b)))
        else $error("A and B moved together");
    a_lock_cause: assert property ($changed(key_lock) |-> age_q <= 3'h3)
        else $error("lock moved without cause");
    a_read_unmapped: assert property (hsel && htrans[1] && hready && !hwrite && haddr >= 32'h20
        |=> hrdata == '0) else $error("unmapped read not zero");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    c_marker: cover property ($rose(out_z));
    c_lock: cover property ($rose(key_lock));
    c_quad: cover property ($changed(out_a) ##7 $changed(out_b));
endmodule

bind qprs_top qprs_checker #(.CTL_INPUTS(CTL_INPUTS), .GAP_WIDTH(GAP_WIDTH)) u_qprs_checker (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ctl_in(ctl_in), .out_a(out_a), .out_a_n(out_a_n), .out_b(out_b), .out_b_n(out_b_n),
    .out_z(out_z), .out_z_n(out_z_n), .key_lock(key_lock));

/* tb/qprs_enc_model.sv */
// Encoder source and downstream quadrature counter around the scaler.
module qprs_enc_model (
    input wire logic ref_clk,
    input wire logic out_a,
    input wire logic out_b,
    output logic enc_a,
    output logic enc_b,
    output logic enc_z
);
    timeunit 1ns;
    timeprecision 1ps;
    // Steps at least seven cycles apart keep the input at or below 1 MHz pulses.
    localparam int MIN_GAP = 6;
    int pos = 0;
    int bad = 0;
    logic [1:0] ph = 2'h0;
    logic [1:0] oi = 2'h0;
    logic [1:0] ni;
    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        enc_z = 1'b0;
    end
    task automatic step(input int dir);
        @(posedge ref_clk);
        ph = ph + dir[1:0];
        enc_a <= ph[0] ^ ph[1];
        enc_b <= ph[1];
        repeat (MIN_GAP) @(posedge ref_clk);
    endtask
    task automatic marker();
        @(posedge ref_clk);
        enc_z <= 1'b1;
        repeat (3) @(posedge ref_clk);
        enc_z <= 1'b0;
    endtask
    // A jump of two states means the phases lost their separation.
    always @(posedge ref_clk) begin
        ni = {out_b, out_a ^ out_b};
        if (ni - oi == 2'd1) pos++;
        else if (ni - oi == 2'd3) pos--;
        else if (ni - oi == 2'd2) bad++;
        oi = ni;
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the quadrature pulse rate scaler.
`include "qprs_cfg.svh"
module tb_top;
    import qprs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0;
    logic reset_n = 0;
    logic hsel = 0;
    logic [31:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [2:0] hsize = 3'h2;
    qprs_word_t hwdata = 0;
    qprs_word_t hrdata;
    qprs_word_t d;
    logic hready, hresp, key_lock, enc_a, enc_b, enc_z;
    logic [3:0] ctl_in = 4'h0;
    logic out_a, out_a_n, out_b, out_b_n, out_z, out_z_n;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    always #20 ref_clk = ~ref_clk;
    qprs_top u_qprs_top (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .enc_a(enc_a), .enc_b(enc_b),
        .enc_z(enc_z), .ctl_in(ctl_in), .out_a(out_a), .out_a_n(out_a_n), .out_b(out_b),
        .out_b_n(out_b_n), .out_z(out_z), .out_z_n(out_z_n), .key_lock(key_lock));
    qprs_enc_model u_qprs_enc_model (.ref_clk(ref_clk), .out_a(out_a), .out_b(out_b),
        .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input qprs_word_t got, input qprs_word_t exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic xfer(input logic [31:0] a, input logic w, input qprs_word_t wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        d = hrdata;
    endtask
    task automatic rdc(input logic [31:0] a, input qprs_word_t e);
        xfer(a, 1'b0, '0);
        chk(d, e);
    endtask
    task automatic mv(input int dir, input int n);
        repeat (n) u_qprs_enc_model.step(dir);
    endtask
    // Waits for the counted output position, then compares it and the register.
    task automatic settle(input int e);
        for (int n = 0; n < 4000 && u_qprs_enc_model.pos != e; n++) @(posedge ref_clk);
        chk(u_qprs_enc_model.pos, e);
        rdc(`QPRS_OFS_POSITION, e);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(out_z, 1'b1);
        chk(out_a_n, 1'b1);
        rdc(`QPRS_OFS_CTRL, 32'h1);
        rdc(`QPRS_OFS_FACTOR1, 32'h2710);
        rdc(`QPRS_OFS_FACTOR2, 32'h2710);
        rdc(`QPRS_OFS_MARKER_PPR, 32'h400);
        rdc(`QPRS_OFS_CTLIN_CFG, 32'h0);
        rdc(32'h20, 32'h0);
    endtask
    task automatic t_ratio();
        mv(1, 8);
        mv(-1, 3);
        settle(5);
        xfer(`QPRS_OFS_FACTOR1, 1'b1, 32'd25000);
        xfer(`QPRS_OFS_FACTOR2, 1'b1, 32'd9000);
        xfer(`QPRS_OFS_FACTOR1, 1'b1, 32'd4);
        xfer(`QPRS_OFS_FACTOR2, 1'b1, 32'd100000);
        rdc(`QPRS_OFS_FACTOR1, 32'd25000);
        rdc(`QPRS_OFS_FACTOR2, 32'd9000);
        mv(1, 9);
        settle(30);
        mv(1, 1);
        settle(32);
        mv(-1, 1);
        settle(30);
        mv(-1, 9);
        settle(5);
        xfer(`QPRS_OFS_FACTOR1, 1'b1, 32'h2710);
        xfer(`QPRS_OFS_FACTOR2, 1'b1, 32'h2710);
    endtask
    task automatic t_single();
        xfer(`QPRS_OFS_CTRL, 1'b1, 32'h0);
        mv(1, 8);
        settle(7);
        xfer(`QPRS_OFS_CTRL, 1'b1, 32'h4);
        mv(1, 4);
        settle(6);
        xfer(`QPRS_OFS_CTRL, 1'b1, 32'h1);
    endtask
    task automatic t_marker();
        xfer(`QPRS_OFS_MARKER_PPR, 1'b1, 32'h1);
        // The first up edge after a shorter marker period starts a new period.
        mv(1, 1);
        settle(7);
        chk(out_z, 1'b1);
        mv(1, 1);
        settle(8);
        chk(out_z, 1'b0);
        mv(1, 3);
        settle(11);
        chk(out_z, 1'b1);
        mv(1, 1);
        settle(12);
        chk(out_z, 1'b0);
        xfer(`QPRS_OFS_CTRL, 1'b1, 32'h3);
        u_qprs_enc_model.marker();
        rdc(`QPRS_OFS_POSITION, 32'd12);
        chk(out_z, 1'b1);
        xfer(`QPRS_OFS_MARKER_PPR, 1'b1, 32'h0);
        rdc(`QPRS_OFS_MARKER_PPR, 32'h0);
        chk(out_z, 1'b0);
        xfer(`QPRS_OFS_CTRL, 1'b1, 32'h1);
    endtask
    task automatic t_ctl();
        for (int i = 0; i < 4; i++) begin
            xfer(`QPRS_OFS_CTLIN_CFG, 1'b1, (32'h2 | (i % 2)) << (4 * i));
            ctl_in <= (i % 2) ? 4'h0 : 4'hf;
            repeat (3) @(posedge ref_clk);
            chk(key_lock, 1'b0);
            ctl_in[i] <= 1'(i % 2);
            repeat (3) @(posedge ref_clk);
            chk(key_lock, 1'b1);
        end
        xfer(`QPRS_OFS_CTLIN_CFG, 1'b1, 32'h4);
        ctl_in <= 4'he;
        mv(1, 4);
        for (int n = 0; n < 4000 && u_qprs_enc_model.pos != 8; n++) @(posedge ref_clk);
        chk(u_qprs_enc_model.pos, 8);
        rdc(`QPRS_OFS_STATUS, 32'h2);
        xfer(`QPRS_OFS_CTLIN_CFG, 1'b1, 32'h7);
        ctl_in <= 4'h1;
        @(posedge ref_clk);
        xfer(`QPRS_OFS_STATUS, 1'b0, '0);
        chk(d[2], 1'b1);
        ctl_in <= 4'h0;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_ratio();
        t_single();
        t_marker();
        t_ctl();
        chk(u_qprs_enc_model.bad, 0);
        end_of_test();
    end
endmodule
